// File: rtl/backlight_brightness_dimming.sv
/*
 Brightness engine: register port, PWM duty meter, effective code,
 ramp, staggered sink pulses and output over-voltage guard.
 Assumes pwmIn, ovHigh and ovLow are asynchronous pins; rstn low
 whenever the device is disabled.
*/
// Functional notes
// - Source 00 uses only the register word; PWM input is ignored.
// - Word is low nibble plus high byte; high byte write applies it.
// - Register codes 256..4095 give continuous current of half even code.
// - Register codes 16..255 use full amplitude, duty follows code.
// - Register codes 1..15 use duty 16/256, exponential average.
// - Code zero gives zero current in every source setting.
// - Register ramp steps every 128 us when high nibble nonzero.
// - Register ramp steps every 1024 us when high nibble zero.
// - PWM-only code is duty times 2048, linear current.
// - Codes below 16 in PWM modes pulse at 1/8 duty, amplitude x8.
// - PWM-only source never ramps.
// - Combined code is even word times half times duty.
// - Combined code is linear to 2047 with fractional steps.
// - Combined ramp rate chosen from register high nibble only.
// - Sink pulse windows are offset in phase.
// - Over-voltage valid after 1 ms; boost stops until low threshold.
// - Valid over-voltage sets fault bit zero.
// - Source field 00 reg, 01 PWM, 10/11 combined, resets to 11.
// - Ramp bit resets to zero; one enables ramping.
// - Fault bit zero is read-only and shows over-voltage.
`timescale 1ns/1ns
module backlight_brightness_dimming
    import backlight_pkg::*;
#(
    parameter int RAMP_FAST_CYC = RAMP_FAST_US * CLK_MHZ,
    parameter int RAMP_SLOW_CYC = RAMP_SLOW_US * CLK_MHZ,
    parameter int OVP_QUAL_CYC  = OVP_QUAL_US * CLK_MHZ
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [7:0]        regRdData,
    input  wire logic              pwmIn,
    input  wire logic              ovHigh,
    input  wire logic              ovLow,
    output logic                   boostEnable,
    output logic      [2:0]        sinkOn,
    output logic      [LVL_W-1:0]  sinkLevel
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] syncA, syncB;
    logic       pwmPrev;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syncA   <= 3'h0;
            syncB   <= 3'h0;
            pwmPrev <= 1'b0;
        end else begin
            syncA   <= {ovLow, ovHigh, pwmIn};
            syncB   <= syncA;
            pwmPrev <= syncB[0];
        end
    end
    wire pwmLvl  = syncB[0];
    wire ovHi    = syncB[1];
    wire ovLo    = syncB[2];
    wire pwmRise = pwmLvl && !pwmPrev;
    ////////////////////////////////////////////////////////////////////
    // Register file
    ctrl_s      ctrl, next_ctrl;
    logic [3:0] lowNib, next_lowNib;
    logic [7:0] highByte, next_highByte;
    logic [11:0] word, next_word;
    logic [7:0] next_regRdData;
    logic       ovFlag, next_ovFlag;
    logic       ovValid;
    always_comb begin
        next_ctrl     = ctrl;
        next_lowNib   = lowNib;
        next_highByte = highByte;
        next_word     = word;
        if (regWr) begin
            case (regAddr)
                ADDR_SINK_EN: next_ctrl.sinkEn = regWrData[SINK_EN_LSB+:3];
                ADDR_CTRL: begin
                    next_ctrl.mode   =
                        dim_mode_e'(regWrData[CTRL_MODE_LSB+:2]);
                    next_ctrl.rampEn = regWrData[CTRL_RAMP_BIT];
                end
                ADDR_BRT_LO: next_lowNib = regWrData[3:0];
                ADDR_BRT_HI: begin
                    next_highByte = regWrData;
                    next_word     = {regWrData, lowNib};
                end
                default: ;
            endcase
        end
        next_ovFlag = ovFlag || ovValid;
        case (regAddr)
            ADDR_SINK_EN: next_regRdData = {4'h0, ctrl.sinkEn, 1'b1};
            ADDR_CTRL:    next_regRdData = {1'b0, ctrl.mode, ctrl.rampEn,
                                            CTRL_RSV};
            ADDR_BRT_HI:  next_regRdData = highByte;
            ADDR_BRT_LO:  next_regRdData = {LO_RSV, lowNib};
            ADDR_FAULT:   next_regRdData = {7'h00, ovFlag};
            default:      next_regRdData = RD_ZERO;
        endcase
        if (!regRd)
            next_regRdData = RD_ZERO;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl      <= '{mode: dim_mode_e'(MODE_RST), rampEn: RAMP_RST,
                           sinkEn: SINK_EN_RST};
            lowNib    <= BRT_LO_RST;
            highByte  <= BRT_HI_RST;
            word      <= {BRT_HI_RST, BRT_LO_RST};
            ovFlag    <= 1'b0;
            regRdData <= RD_ZERO;
        end else begin
            ctrl      <= next_ctrl;
            lowNib    <= next_lowNib;
            highByte  <= next_highByte;
            word      <= next_word;
            ovFlag    <= next_ovFlag;
            regRdData <= next_regRdData;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Duty meter: one divide per input period; a stuck pin reads 0 or 1
    logic [MEAS_W-1:0] perCnt, next_perCnt, highCnt, next_highCnt;
    logic [23:0] num, next_num, den, next_den;
    logic [12:0] quo, next_quo, duty, next_duty;
    logic [3:0]  divLeft, next_divLeft;
    wire perSat = &perCnt;
    always_comb begin
        next_perCnt  = perSat ? perCnt : perCnt + 1'b1;
        next_highCnt = (pwmLvl && !(&highCnt)) ? highCnt + 1'b1 : highCnt;
        next_num     = num;
        next_den     = den;
        next_quo     = quo;
        next_divLeft = divLeft;
        next_duty    = duty;
        if (pwmRise) begin
            if (!perSat) begin
                next_num     = {highCnt, 12'h000};
                next_den     = {perCnt, 12'h000};
                next_quo     = 13'h0000;
                next_divLeft = DIV_STEPS;
            end
            next_perCnt  = {{(MEAS_W-1){1'b0}}, 1'b1};
            next_highCnt = {{(MEAS_W-1){1'b0}}, 1'b1};
        end else if (divLeft != 4'h0) begin
            next_quo = {quo[11:0], num >= den};
            if (num >= den)
                next_num = num - den;
            next_den     = den >> 1;
            next_divLeft = divLeft - 1'b1;
            if (divLeft == 4'h1)
                next_duty = (next_quo > DUTY_ONE) ? DUTY_ONE : next_quo;
        end else if (perSat) begin
            next_duty = pwmLvl ? DUTY_ONE : 13'h0000;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            perCnt  <= '0;
            highCnt <= '0;
            num     <= 24'h000000;
            den     <= 24'h000000;
            quo     <= 13'h0000;
            divLeft <= 4'h0;
            duty    <= 13'h0000;
        end else begin
            perCnt  <= next_perCnt;
            highCnt <= next_highCnt;
            num     <= next_num;
            den     <= next_den;
            quo     <= next_quo;
            divLeft <= next_divLeft;
            duty    <= next_duty;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Effective code and ramp, average held in Q8 units of one LSB
    logic [LVL_W-1:0] target, cur, next_cur;
    logic [15:0]      tick, next_tick;
    logic [24:0]      mixProd;
    logic [LVL_W-1:0] diff;
    wire [11:0] evenWord   = {word[11:1], 1'b0};
    wire        rampActive = ctrl.rampEn && ctrl.mode != MODE_PWM;
    wire        fastRate   = word[11:8] != 4'h0;
    always_comb begin
        mixProd = evenWord * duty;
        case (ctrl.mode)
            MODE_REG: begin
                if (word <= CODE_EXP_TOP)
                    target = {8'h00, EXP_Q8[word[3:0]]};
                else
                    target = {1'b0, word[11:1], 8'h00};
            end
            MODE_PWM: target = {duty, 7'h00};
            default:  target = mixProd[24:5];
        endcase
        diff      = (cur > target) ? cur - target : target - cur;
        next_cur  = cur;
        next_tick = tick;
        if (!rampActive) begin
            next_cur  = target;
            next_tick = 16'h0000;
        end else if (tick == 16'h0000) begin
            next_tick = fastRate ? 16'(RAMP_FAST_CYC - 1)
                                 : 16'(RAMP_SLOW_CYC - 1);
            if (diff <= STEP_Q8)
                next_cur = target;
            else if (cur < target)
                next_cur = cur + STEP_Q8;
            else
                next_cur = cur - STEP_Q8;
        end else begin
            next_tick = tick - 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur  <= '0;
            tick <= 16'h0000;
        end else begin
            cur  <= next_cur;
            tick <= next_tick;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Pulse shaping and phase-staggered sinks
    logic [7:0]       phase;
    logic [8:0]       dutyLen;
    logic [LVL_W-1:0] amp;
    logic [2:0]       next_sinkOn;
    logic [7:0]       off [3];
    logic [1:0]       rank [3];
    logic [1:0]       nEn;
    always_comb begin
        if (ctrl.mode == MODE_REG) begin
            if (cur >= FULL_Q8) begin
                dutyLen = DUTY_FULL;
                amp     = cur;
            end else if (cur >= KNEE_REG_Q8) begin
                dutyLen = {1'b0, cur[14:7]};
                amp     = FULL_Q8;
            end else begin
                dutyLen = DUTY_16TH;
                amp     = cur << AMP_X16_SH;
            end
        end else if (cur < KNEE_HYB_Q8) begin
            dutyLen = DUTY_8TH;
            amp     = cur << AMP_X8_SH;
        end else begin
            dutyLen = DUTY_FULL;
            amp     = cur;
        end
        nEn     = 2'(ctrl.sinkEn[0]) + 2'(ctrl.sinkEn[1])
                + 2'(ctrl.sinkEn[2]);
        rank[0] = 2'h0;
        rank[1] = 2'(ctrl.sinkEn[0]);
        rank[2] = 2'(ctrl.sinkEn[0]) + 2'(ctrl.sinkEn[1]);
        for (int i = 0; i < 3; i++) begin
            if (nEn == 2'h3)
                off[i] = (rank[i] == 2'h1) ? PH_THIRD
                       : (rank[i] == 2'h2) ? PH_2THIRD : 8'h00;
            else if (nEn == 2'h2 && rank[i] == 2'h1)
                off[i] = PH_HALF;
            else
                off[i] = 8'h00;
            next_sinkOn[i] = ctrl.sinkEn[i] && cur != '0
                && {1'b0, 8'(phase - off[i])} < dutyLen;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase     <= 8'h00;
            sinkOn    <= 3'h0;
            sinkLevel <= '0;
        end else begin
            phase     <= phase + 1'b1;
            sinkOn    <= next_sinkOn;
            sinkLevel <= amp;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Over-voltage guard; filter rejects spikes shorter than the window
    ov_state_e  ovState, next_ovState;
    logic [15:0] ovCnt, next_ovCnt;
    always_comb begin
        next_ovState = ovState;
        next_ovCnt   = 16'h0000;
        ovValid      = 1'b0;
        case (ovState)
            OV_RUN:  if (ovHi) next_ovState = OV_QUAL;
            OV_QUAL: begin
                if (!ovHi) begin
                    next_ovState = OV_RUN;
                end else if (ovCnt >= 16'(OVP_QUAL_CYC)) begin
                    next_ovState = OV_TRIP;
                    ovValid      = 1'b1;
                end else begin
                    next_ovCnt = ovCnt + 1'b1;
                end
            end
            OV_TRIP: if (ovLo) next_ovState = OV_RUN;
            default: next_ovState = OV_RUN;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ovState     <= OV_RUN;
            ovCnt       <= 16'h0000;
            boostEnable <= 1'b0;
        end else begin
            ovState     <= next_ovState;
            ovCnt       <= next_ovCnt;
            boostEnable <= next_ovState != OV_TRIP;
        end
    end
    ////////////////////////////////////////////////////////////////////
    a_ov_qualified: assert property ($rose(ovFlag) |->
        $past(ovHi, 1) && $past(ovHi, 2) && ovState == OV_TRIP)
        else $error("over-voltage flagged without a held input");
    a_boost_stopped: assert property (ovState == OV_TRIP |-> !boostEnable)
        else $error("boost running during over-voltage trip");
    a_flag_sticky: assert property (ovFlag |=> ovFlag)
        else $error("over-voltage bit cleared while enabled");
    a_fault_read: assert property (regRd && regAddr == ADDR_FAULT |=>
        regRdData[FAULT_OV_BIT] == $past(ovFlag))
        else $error("fault read does not show the flag");
    a_low_no_apply: assert property (regWr && regAddr == ADDR_BRT_LO |=>
        $stable(word))
        else $error("low nibble write changed applied word");
    a_high_apply: assert property (regWr && regAddr == ADDR_BRT_HI |=>
        word == {$past(regWrData), $past(lowNib)})
        else $error("high byte write did not apply the word");
    a_pwm_no_ramp: assert property (ctrl.mode == MODE_PWM ##1
        ctrl.mode == MODE_PWM |-> cur == $past(target))
        else $error("PWM-only level did not follow at once");
    a_ramp_step: assert property (rampActive && $past(rampActive) |->
        (cur - $past(cur) <= STEP_Q8) || ($past(cur) - cur <= STEP_Q8))
        else $error("ramp moved more than one step");
    a_eighth_duty: assert property (ctrl.mode != MODE_REG && cur != '0
        && cur < KNEE_HYB_Q8 |-> dutyLen == DUTY_8TH)
        else $error("low code not pulsed at one eighth");
    a_zero_dark: assert property (cur == '0 |=> sinkOn == 3'h0)
        else $error("sink on with zero level");
endmodule : backlight_brightness_dimming

// File: rtl/backlight_pkg.sv
/*
 Shared constants and types of the backlight dimming engine.
 Assumes a 50 MHz core clock and an 8-bit register port.
*/
package backlight_pkg;
    localparam int CLK_MHZ      = 50;
    localparam int RAMP_FAST_US = 128;
    localparam int RAMP_SLOW_US = 1024;
    localparam int OVP_QUAL_US  = 1000;
    ////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ADDR_SINK_EN = 8'h10;
    localparam logic [7:0] ADDR_CTRL    = 8'h11;
    localparam logic [7:0] ADDR_BRT_HI  = 8'h19;
    localparam logic [7:0] ADDR_BRT_LO  = 8'h1a;
    localparam logic [7:0] ADDR_FAULT   = 8'h1f;
    localparam logic [7:0] RD_ZERO      = 8'h00;
    localparam int         SINK_EN_LSB  = 1;
    localparam int         CTRL_MODE_LSB = 5;
    localparam int         CTRL_RAMP_BIT = 4;
    localparam int         FAULT_OV_BIT  = 0;
    localparam logic [2:0] SINK_EN_RST  = 3'h7;
    localparam logic [1:0] MODE_RST     = 2'h3;
    localparam logic       RAMP_RST     = 1'b0;
    localparam logic [7:0] BRT_HI_RST   = 8'hff;
    localparam logic [3:0] BRT_LO_RST   = 4'hf;
    localparam logic [3:0] CTRL_RSV     = 4'h5;
    localparam logic [3:0] LO_RSV       = 4'hf;
    ////////////////////////////////////////////////////////////////////
    localparam int          LVL_W       = 20;
    localparam int          MEAS_W      = 12;
    localparam logic [19:0] STEP_Q8     = 20'h00100;
    localparam logic [19:0] FULL_Q8     = 20'h08000;
    localparam logic [19:0] KNEE_REG_Q8 = 20'h00800;
    localparam logic [19:0] KNEE_HYB_Q8 = 20'h01000;
    localparam logic [11:0] CODE_EXP_TOP = 12'h00f;
    localparam logic [8:0]  DUTY_FULL   = 9'h100;
    localparam logic [8:0]  DUTY_16TH   = 9'h010;
    localparam logic [8:0]  DUTY_8TH    = 9'h020;
    localparam int          AMP_X16_SH  = 4;
    localparam int          AMP_X8_SH   = 3;
    localparam logic [12:0] DUTY_ONE    = 13'h1000;
    localparam logic [3:0]  DIV_STEPS   = 4'hd;
    localparam logic [7:0]  PH_THIRD    = 8'h55;
    localparam logic [7:0]  PH_2THIRD   = 8'hab;
    localparam logic [7:0]  PH_HALF     = 8'h80;
    // Average in Q8 units for codes 1..15 (growth 1.149 per code)
    localparam logic [11:0] EXP_Q8 [0:15] = '{12'h000, 12'h100, 12'h126,
        12'h152, 12'h184, 12'h1be, 12'h201, 12'h24d, 12'h2a5, 12'h30a,
        12'h37e, 12'h403, 12'h49c, 12'h54b, 12'h615, 12'h6fd};
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        MODE_REG = 2'h0, MODE_PWM = 2'h1, MODE_MIX_A = 2'h2, MODE_MIX_B = 2'h3
    } dim_mode_e;
    typedef enum logic [1:0] {
        OV_RUN = 2'h0, OV_QUAL = 2'h1, OV_TRIP = 2'h3
    } ov_state_e;
    typedef struct packed {
        dim_mode_e  mode;
        logic       rampEn;
        logic [2:0] sinkEn;
    } ctrl_s;
endpackage : backlight_pkg

// File: testbench/pwm_host_model.sv
/*
 Host side of the PWM dimming pin: a steady pulse train or a stuck level.
 Assumes the bench picks a period inside the allowed frequency band.
*/
`timescale 1ns/1ns
module pwm_host_model (
    input  wire logic        sys_clk,
    input  wire logic        run,
    input  wire logic [11:0] periodCyc,
    input  wire logic [11:0] highCyc,
    input  wire logic        idleLevel,
    output logic             pwmOut
);
    // No reset pin here: a known start keeps the pulse train defined
    logic [11:0] phase = 12'h000;
    logic [11:0] next_phase;
    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_phase = phase + 12'h001;
        if (!run || phase >= periodCyc - 12'h001) begin
            next_phase = 12'h000;
        end
    end
    // Period of 1024 cycles at 50 MHz stays inside 20..100 kHz
    always @(posedge sys_clk) begin
        phase  <= next_phase;
        pwmOut <= run ? (phase < highCyc) : idleLevel;
    end
endmodule : pwm_host_model

// File: testbench/backlight_brightness_dimming_tb.sv
/*
 Self-checking bench of the brightness engine.
 Assumes the PWM host model and shortened ramp and guard counts.
*/
`timescale 1ns/1ns
module backlight_brightness_dimming_tb import backlight_pkg::*;;
    logic             sys_clk   = 1'b0;
    logic             rstn      = 1'b0;
    logic [7:0]       regAddr   = 8'h00;
    logic [7:0]       regWrData = 8'h00;
    logic             regWr     = 1'b0;
    logic             regRd     = 1'b0;
    logic [7:0]       regRdData;
    logic             pwmRun    = 1'b1;
    logic [11:0]      pwmHigh   = 12'h200;
    logic             pwmIdle   = 1'b0;
    logic             pwmIn;
    logic             ovHigh    = 1'b0;
    logic             ovLow     = 1'b0;
    logic             boostEnable;
    logic [2:0]       sinkOn;
    logic [LVL_W-1:0] sinkLevel;
    int               mismatches = 0;
    int               checksDone = 0;
    always #10 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////
    pwm_host_model host (.sys_clk(sys_clk), .run(pwmRun),
        .periodCyc(12'h400), .highCyc(pwmHigh), .idleLevel(pwmIdle),
        .pwmOut(pwmIn));
    // Short counts keep the run small; expectations follow these values
    backlight_brightness_dimming #(.RAMP_FAST_CYC(8), .RAMP_SLOW_CYC(32),
        .OVP_QUAL_CYC(20)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .pwmIn(pwmIn),
        .ovHigh(ovHigh), .ovLow(ovLow), .boostEnable(boostEnable),
        .sinkOn(sinkOn), .sinkLevel(sinkLevel));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [19:0] seen,
                         input logic [19:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask : rd
    task automatic set_word(input logic [11:0] w);
        wr(ADDR_BRT_LO, {4'h0, w[3:0]}); // Low nibble goes first
        wr(ADDR_BRT_HI, w[11:4]);
    endtask : set_word
    task automatic set_ctrl(input dim_mode_e m, input logic ramp);
        wr(ADDR_CTRL, {1'b0, m, ramp, 4'h0});
    endtask : set_ctrl
    // Any 256 consecutive cycles hold exactly one slot frame
    task automatic check_pulse(input int e0, input int e1, input int e2,
                               input int eOv);
        int n [4];
        n = '{0, 0, 0, 0};
        repeat (256) begin
            @(posedge sys_clk);
            #1;
            for (int i = 0; i < 3; i++) n[i] += int'(sinkOn[i] === 1'b1);
            n[3] += int'($countones(sinkOn) > 1);
        end
        check("sink0 on", 20'(n[0]), 20'(e0));
        check("sink1 on", 20'(n[1]), 20'(e1));
        check("sink2 on", 20'(n[2]), 20'(e2));
        check("sinks overlap", 20'(n[3]), 20'(eOv));
    endtask : check_pulse
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] d;
        logic [7:0] addrs [6] = '{ADDR_SINK_EN, ADDR_CTRL, ADDR_BRT_HI,
                                  ADDR_BRT_LO, ADDR_FAULT, 8'h33};
        logic [7:0] exps [6] = '{8'h0f, 8'h65, 8'hff, 8'hff, 8'h00, 8'h00};
        wr(ADDR_FAULT, 8'hff);
        wr(8'h33, 8'hff);
        for (int i = 0; i < 6; i++) begin
            rd(addrs[i], d);
            check("reset", 20'(d), 20'(exps[i]));
        end
        $display("test reset done");
    endtask : t_reset
    task automatic t_reg;
        set_ctrl(MODE_REG, 1'b0);
        set_word(12'h800);
        settle(8);
        check("level 800", sinkLevel, 20'h40000);
        check("sinks full", {17'h0, sinkOn}, 20'h00007);
        wr(ADDR_BRT_LO, 8'h02);
        settle(8);
        check("level nibble only", sinkLevel, 20'h40000);
        wr(ADDR_BRT_HI, 8'h80);
        settle(8);
        check("level 802", sinkLevel, 20'h40100);
        set_word(12'h803);
        pwmHigh <= 12'h064;
        settle(3200);
        check("level odd word", sinkLevel, 20'h40100);
        $display("test reg_only done");
    endtask : t_reg
    task automatic t_low;
        set_word(12'h040);
        settle(8);
        check("level 040", sinkLevel, 20'h08000);
        check_pulse(9'h040, 9'h040, 9'h040, 9'h000);
        set_word(12'h005);
        settle(8);
        check("level 005", sinkLevel, {4'h0, EXP_Q8[5], 4'h0});
        check_pulse(9'h010, 9'h010, 9'h010, 9'h000);
        wr(ADDR_SINK_EN, 8'h06);
        set_word(12'h064);
        settle(8);
        check_pulse(9'h064, 9'h064, 9'h000, 9'h000);
        set_word(12'h000);
        settle(8);
        check("level zero", sinkLevel, 20'h00000);
        check_pulse(9'h000, 9'h000, 9'h000, 9'h000);
        wr(ADDR_SINK_EN, 8'h0e);
        $display("test low_codes done");
    endtask : t_low
    task automatic t_pwm;
        set_word(12'h800); // Word kept nonzero
        set_ctrl(MODE_PWM, 1'b1);
        pwmHigh <= 12'h100;
        // A ramp would need 4096 cycles to get there
        settle(3200);
        check("level pwm quarter", sinkLevel, 20'h20000);
        pwmHigh <= 12'h004;
        settle(3200);
        check("level pwm low", sinkLevel, 20'h04000);
        check_pulse(9'h020, 9'h020, 9'h020, 9'h000);
        pwmRun <= 1'b0;
        settle(4500);
        check("level pwm stuck low", sinkLevel, 20'h00000);
        pwmRun  <= 1'b1;
        pwmHigh <= 12'h200;
        settle(3200);
        $display("test pwm_only done");
    endtask : t_pwm
    task automatic t_mix;
        dim_mode_e modes [2] = '{MODE_MIX_A, MODE_MIX_B};
        for (int i = 0; i < 2; i++) begin
            set_ctrl(modes[i], 1'b0);
            set_word(12'h801);
            settle(20);
            check("level mix", sinkLevel, 20'h20000);
        end
        set_word(12'h00b);
        settle(20);
        check("level mix frac", sinkLevel, 20'h01400);
        $display("test combined done");
    endtask : t_mix
    task automatic ramp_gap(input dim_mode_e m, input logic [11:0] fromW,
        input logic [11:0] toW, input int gap, input logic [19:0] endLvl);
        logic [19:0] lvl;
        int          n;
        set_ctrl(m, 1'b0);
        set_word(fromW);
        settle(20);
        set_ctrl(m, 1'b1);
        set_word(toW);
        // Second wait spans exactly one step period
        for (int k = 0; k < 2; k++) begin
            lvl = sinkLevel;
            n = 0;
            while (sinkLevel === lvl && n < 300) begin
                @(posedge sys_clk);
                #1;
                n++;
            end
        end
        check("ramp step gap", 20'(n), 20'(gap));
        settle(300);
        check("ramp end level", sinkLevel, endLvl);
    endtask : ramp_gap
    task automatic t_ramp;
        ramp_gap(MODE_REG, 12'h800, 12'h804, 8'h08, 20'h40200);
        // Low codes keep amplitude tracking the level, so each step shows
        ramp_gap(MODE_REG, 12'h00c, 12'h00f, 32, 20'h06fd0);
        pwmIdle <= 1'b1;
        pwmRun  <= 1'b0;
        settle(4500);
        ramp_gap(MODE_MIX_A, 12'h0f0, 12'h0f4, 8'h20, 20'h07a00);
        ramp_gap(MODE_MIX_A, 12'h800, 12'h804, 8'h08, 20'h40200);
        $display("test ramp done");
    endtask : t_ramp
    task automatic t_ovp;
        logic [7:0] d;
        @(posedge sys_clk);
        ovHigh <= 1'b1;
        settle(12);
        @(posedge sys_clk);
        ovHigh <= 1'b0;
        settle(6);
        check("boost short", {19'h0, boostEnable}, 20'h00001);
        rd(ADDR_FAULT, d);
        check("flag after short", {12'h0, d}, 20'h00000);
        @(posedge sys_clk);
        ovHigh <= 1'b1;
        settle(30);
        check("boost tripped", {19'h0, boostEnable}, 20'h00000);
        @(posedge sys_clk);
        ovHigh <= 1'b0;
        settle(10);
        check("boost held off", {19'h0, boostEnable}, 20'h00000);
        rd(ADDR_FAULT, d);
        check("flag set", {12'h0, d}, 20'h00001);
        @(posedge sys_clk);
        ovLow <= 1'b1;
        settle(6);
        check("boost back", {19'h0, boostEnable}, 20'h00001);
        @(posedge sys_clk);
        ovLow <= 1'b0;
        $display("test overvoltage done");
    endtask : t_ovp
    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_reg();
        t_low();
        t_pwm();
        t_mix();
        t_ramp();
        t_ovp();
        report_and_stop();
    end
    // Tests need about 25000 cycles; over twice that means a hang
    initial begin
        #1_200_000;
        mismatches++;
        report_and_stop();
    end
endmodule : backlight_brightness_dimming_tb
